/* verilog/tpb_prbs_self_test.sv */
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none

module tpb_prbs_self_test
   import tpb_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // transmit side
   output logic [19:0] tx_par_data,
   output logic codec_bypass,
   output logic ser_lpbk_en,
   // receive side, same clock as the word aligner
   input wire logic [19:0] rx_aligned_data,
   input wire logic rx_sync_status,
   output logic [39:0] align_pattern,
   // asynchronous pins
   input wire logic tx_digital_reset,
   input wire logic rx_digital_reset,
   input wire logic ser_lpbk_req,
   // status
   output logic rx_done,
   output logic rx_err,
   output logic irq
);

   // =====================================================
   // pin synchronisers
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
      end else begin
         sync1_q <= {ser_lpbk_req, rx_digital_reset, tx_digital_reset};
         sync2_q <= sync1_q;
      end
   end

   // =====================================================
   // apb slave
   logic [8:0] ctrl_q;
   logic [1:0] irq_stat_q;
   logic [1:0] irq_mask_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic done_q;
   logic err_q;
   tpb_chk_state_t chk_q;
   logic cfg_ok;

   // answer comes one cycle into the access phase, so read data can be a flop
   wire logic access = psel & penable & ~pready_q;
   wire logic fire = psel & penable & pready_q;
   wire logic hit_ctrl = (paddr == ADDR_CTRL);
   wire logic hit_status = (paddr == ADDR_STATUS);
   wire logic hit_istat = (paddr == ADDR_IRQ_STAT);
   wire logic hit_imask = (paddr == ADDR_IRQ_MASK);
   wire logic hit_any = hit_ctrl | hit_status | hit_istat | hit_imask;
   wire logic wr_ctrl = fire & pwrite & hit_ctrl;
   wire logic wr_istat = fire & pwrite & hit_istat;
   wire logic wr_imask = fire & pwrite & hit_imask;
   wire logic [31:0] status_word = {28'h0000000, ~cfg_ok, (chk_q == CHK_RUN), err_q, done_q};
   wire logic [31:0] rd_mux = hit_ctrl ? {23'h000000, ctrl_q} :
                              hit_status ? status_word :
                              hit_istat ? {30'h00000000, irq_stat_q} :
                              hit_imask ? {30'h00000000, irq_mask_q} : 32'h00000000;

   always_ff @(posedge clk) begin
      if (rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         pready_q <= access;
         pslverr_q <= access & ~hit_any;
         if (access) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_mux;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= CTRL_RST;
         irq_mask_q <= IRQ_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= pwdata[CTRL_W-1:0];
         end
         if (wr_imask) begin
            irq_mask_q <= pwdata[1:0];
         end
      end
   end

   // =====================================================
   // mode decode
   wire tpb_mode_t mode = tpb_mode_t'(ctrl_q[CTRL_MODE_LSB +: 3]);
   wire logic [1:0] wsel = ctrl_q[CTRL_WSEL_LSB +: 2];
   wire logic dbl = wsel[1];
   wire logic is_prbs = (mode == MODE_PRBS7) | (mode == MODE_PRBS8) |
                        (mode == MODE_PRBS10) | (mode == MODE_PRBS23);
   wire logic [4:0] nbits = (wsel == WSEL_8) ? NBITS_8 :
                            (wsel == WSEL_10) ? NBITS_10 :
                            (wsel == WSEL_16) ? NBITS_16 : NBITS_20;
   wire logic [19:0] wmask = ~(20'hFFFFF << nbits);
   wire logic [4:0] order = (mode == MODE_PRBS8) ? P8_ORDER :
                            (mode == MODE_PRBS10) ? P10_ORDER :
                            (mode == MODE_PRBS23) ? P23_ORDER : P7_ORDER;
   wire logic [4:0] tap = (mode == MODE_PRBS8) ? P8_TAP :
                          (mode == MODE_PRBS10) ? P10_TAP :
                          (mode == MODE_PRBS23) ? P23_TAP : P7_TAP;

   // a pattern not offered at this width leaves the generator and checker quiet
   always_comb begin
      case (mode)
         MODE_PRBS7: cfg_ok = (wsel != WSEL_10);
         MODE_PRBS8: cfg_ok = (wsel == WSEL_8);
         MODE_PRBS10: cfg_ok = (wsel == WSEL_10);
         MODE_PRBS23: cfg_ok = (wsel != WSEL_10);
         MODE_LF: cfg_ok = (wsel == WSEL_10) | (wsel == WSEL_20);
         MODE_INCR: cfg_ok = ctrl_q[CTRL_PLPBK];
         default: cfg_ok = 1'b1;
      endcase
   end

   logic [39:0] align_d;
   always_comb begin
      case (mode)
         MODE_PRBS7: align_d = (wsel == WSEL_20) ? ALIGN_P7_20 : ALIGN_P7;
         MODE_PRBS8: align_d = ALIGN_P8;
         MODE_PRBS10: align_d = ALIGN_P10;
         MODE_PRBS23: align_d = (wsel == WSEL_8) ? ALIGN_P23_8 :
                                (wsel == WSEL_16) ? ALIGN_P23_16 : ALIGN_P23_20;
         default: align_d = 40'h0000000000;
      endcase
   end

   // =====================================================
   // generator
   wire logic tx_rst = rst | sync2_q[0] | ctrl_q[CTRL_TXRST];
   logic [22:0] tx_lfsr_q;
   logic [22:0] tx_lfsr_d;
   logic [19:0] tx_bits;
   logic [19:0] tx_data_q;
   logic [19:0] tx_data_d;

   tpb_prbs_step u_tx_step (
      .order(order),
      .tap(tap),
      .nbits(nbits),
      .state_in(tx_lfsr_q),
      .load(1'b0),
      .data(20'h00000),
      .state_out(tx_lfsr_d),
      .bits(tx_bits)
   );

   always_comb begin
      if (!cfg_ok) begin
         tx_data_d = 20'h00000;
      end else begin
         case (mode)
            MODE_PRBS7, MODE_PRBS8, MODE_PRBS10, MODE_PRBS23: tx_data_d = tx_bits;
            MODE_HF: tx_data_d = HF_WORD & wmask;
            MODE_LF: tx_data_d = dbl ? LF_WORD_20 : LF_WORD_10;
            MODE_INCR: tx_data_d = (tx_data_q + 20'h00001) & wmask;
            default: tx_data_d = 20'h00000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (tx_rst) begin
         tx_lfsr_q <= LFSR_SEED;
         tx_data_q <= 20'h00000;
      end else begin
         if (is_prbs & cfg_ok) begin
            tx_lfsr_q <= tx_lfsr_d;
         end
         tx_data_q <= tx_data_d;
      end
   end

   // =====================================================
   // checker: seed from the aligned stream, then predict and compare
   wire logic rx_rst = rst | sync2_q[1] | ctrl_q[CTRL_RXRST];
   wire logic chk_on = is_prbs & cfg_ok;
   logic [22:0] rx_lfsr_q;
   logic [22:0] rx_lfsr_d;
   logic [22:0] rx_step_state;
   logic [19:0] rx_bits;
   logic [4:0] seed_q;
   logic [4:0] seed_d;
   logic [23:0] cnt_q;
   logic [23:0] cnt_d;
   logic done_d;
   logic err_d;
   tpb_chk_state_t chk_d;

   tpb_prbs_step u_rx_step (
      .order(order),
      .tap(tap),
      .nbits(nbits),
      .state_in(rx_lfsr_q),
      .load(chk_q == CHK_SEED),
      .data(rx_aligned_data),
      .state_out(rx_step_state),
      .bits(rx_bits)
   );

   wire logic mismatch = |((rx_bits ^ rx_aligned_data) & wmask);
   wire logic [5:0] seed_sum = {1'b0, seed_q} + {1'b0, nbits};
   wire logic [24:0] cnt_sum = {1'b0, cnt_q} + {20'h00000, nbits};
   wire logic [23:0] period = ~(24'hFFFFFF << order);
   wire logic run_ok = chk_on & rx_sync_status;

   always_comb begin
      chk_d = chk_q;
      rx_lfsr_d = rx_lfsr_q;
      seed_d = seed_q;
      cnt_d = cnt_q;
      done_d = done_q;
      err_d = err_q;
      case (chk_q)
         CHK_IDLE: begin
            if (run_ok) begin
               chk_d = CHK_SEED;
               seed_d = 5'h00;
            end
         end
         CHK_SEED: begin
            if (!run_ok) begin
               chk_d = CHK_IDLE;
            end else begin
               rx_lfsr_d = rx_step_state;
               seed_d = seed_sum[4:0];
               if (seed_sum >= {1'b0, order}) begin
                  chk_d = CHK_RUN;
               end
            end
         end
         CHK_RUN: begin
            if (!run_ok) begin
               chk_d = CHK_IDLE;
            end else if (mismatch) begin
               err_d = 1'b1;
               done_d = 1'b1;
               chk_d = CHK_HOLD;
            end else begin
               rx_lfsr_d = rx_step_state;
               cnt_d = cnt_sum[24] ? 24'hFFFFFF : cnt_sum[23:0];
               if (cnt_sum >= {1'b0, period}) begin
                  done_d = 1'b1;
               end
            end
         end
         // after an error only a receive reset restarts the check
         CHK_HOLD: chk_d = CHK_HOLD;
         default: chk_d = CHK_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rx_rst) begin
         chk_q <= CHK_IDLE;
         rx_lfsr_q <= LFSR_SEED;
         seed_q <= 5'h00;
         cnt_q <= 24'h000000;
         done_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         chk_q <= chk_d;
         rx_lfsr_q <= rx_lfsr_d;
         seed_q <= seed_d;
         cnt_q <= cnt_d;
         done_q <= done_d;
         err_q <= err_d;
      end
   end

   // =====================================================
   // interrupts: new events win over a same-cycle clear
   wire logic [1:0] irq_events = {err_d & ~err_q, done_d & ~done_q} & {2{~rx_rst}};
   wire logic [1:0] irq_clr = wr_istat ? pwdata[1:0] : 2'h0;

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_stat_q <= IRQ_RST;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_events;
      end
   end

   // =====================================================
   // registered outputs
   logic codec_bypass_q;
   logic ser_lpbk_q;
   logic [39:0] align_q;
   logic rx_done_q;
   logic rx_err_q;
   logic irq_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         codec_bypass_q <= 1'b0;
         ser_lpbk_q <= 1'b0;
         align_q <= 40'h0000000000;
         rx_done_q <= 1'b0;
         rx_err_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         codec_bypass_q <= (mode != MODE_OFF);
         ser_lpbk_q <= ctrl_q[CTRL_SLPBK] & is_prbs & sync2_q[2];
         // a pattern not offered at this width shows no alignment word either
         align_q <= cfg_ok ? align_d : 40'h0000000000;
         rx_done_q <= is_prbs & done_q;
         rx_err_q <= is_prbs & err_q;
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign tx_par_data = tx_data_q;
   assign codec_bypass = codec_bypass_q;
   assign ser_lpbk_en = ser_lpbk_q;
   assign align_pattern = align_q;
   assign rx_done = rx_done_q;
   assign rx_err = rx_err_q;
   assign irq = irq_q;

   // =====================================================
   // assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   chk_done_sticky_hold: assert property (done_q && !rx_rst |=> done_q)
      else $error("done flag dropped without receive reset");
   chk_err_sticky_hold: assert property (err_q && !rx_rst |=> err_q)
      else $error("error flag dropped without receive reset");
   chk_err_sets_done: assert property ($rose(err_q) |-> done_q && chk_q == CHK_HOLD)
      else $error("error did not also raise done");
   chk_hf_word_out: assert property (!tx_rst && mode == MODE_HF |=> tx_data_q == (HF_WORD & $past(wmask)))
      else $error("high-frequency word wrong");
   chk_lf_double_run: assert property (!tx_rst && mode == MODE_LF && wsel == WSEL_20 |=> tx_data_q == LF_WORD_20)
      else $error("low-frequency double-width word wrong");
   chk_no_hf_check: assert property (!is_prbs && chk_q != CHK_HOLD && !rx_rst |=> chk_q == CHK_IDLE)
      else $error("checker active outside PRBS");
   chk_bypass_codec: assert property (mode != MODE_OFF |=> codec_bypass_q)
      else $error("codec not bypassed in test mode");
   chk_tx_reset_clear: assert property (tx_rst |=> tx_data_q == 20'h00000 && tx_lfsr_q == LFSR_SEED)
      else $error("transmit reset did not clear generator");
   chk_rx_reset_clear: assert property (rx_rst |=> !done_q && !err_q ##1 !rx_done_q)
      else $error("receive reset did not clear checker");
   chk_bad_width_quiet: assert property (is_prbs && !cfg_ok && !tx_rst |=> tx_data_q == 20'h00000)
      else $error("unoffered width still generates");
   chk_p7_align_20: assert property (mode == MODE_PRBS7 && wsel == WSEL_20 |=> align_q == ALIGN_P7_20)
      else $error("prbs7 alignment pattern wrong");
   chk_wait_lock_idle: assert property (chk_q == CHK_IDLE && !rx_sync_status && !rx_rst |=> chk_q == CHK_IDLE)
      else $error("checker started before aligner lock");
   chk_status_gated: assert property (!is_prbs |=> !rx_done_q && !rx_err_q)
      else $error("status visible outside PRBS");
   chk_lpbk_gated: assert property (ser_lpbk_q |-> $past(is_prbs) && $past(ctrl_q[CTRL_SLPBK]))
      else $error("loopback enabled outside PRBS");

   cov_clean_done: cover property (chk_q == CHK_RUN ##1 $rose(done_q) && !err_q);
   cov_error_seen: cover property ($rose(err_q));
   cov_lpbk_on: cover property ($rose(ser_lpbk_q));
   cov_irq_raised: cover property ($rose(irq_q));

endmodule : tpb_prbs_self_test

`default_nettype wire

/* verilog/tpb_pkg.sv */
package tpb_pkg;

   // =====================================================
   // datapath sizes
   localparam int unsigned TPB_LANE_W = 20;
   localparam int unsigned TPB_LFSR_W = 23;
   localparam int unsigned TPB_ALIGN_W = 40;

   // =====================================================
   // register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;

   // control fields
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_WSEL_LSB = 3;
   localparam int unsigned CTRL_PLPBK = 5;
   localparam int unsigned CTRL_TXRST = 6;
   localparam int unsigned CTRL_RXRST = 7;
   localparam int unsigned CTRL_SLPBK = 8;
   localparam int unsigned CTRL_W = 9;
   localparam logic [8:0] CTRL_RST = 9'h000;

   // status and interrupt fields
   localparam int unsigned ST_DONE = 0;
   localparam int unsigned ST_ERR = 1;
   localparam int unsigned ST_CHECKING = 2;
   localparam int unsigned ST_CFG_ERR = 3;
   localparam logic [1:0] IRQ_RST = 2'h0;

   // =====================================================
   // pattern modes and channel widths
   typedef enum logic [2:0] {
      MODE_OFF = 3'b000,
      MODE_PRBS7 = 3'b001,
      MODE_PRBS8 = 3'b010,
      MODE_PRBS10 = 3'b011,
      MODE_PRBS23 = 3'b100,
      MODE_HF = 3'b101,
      MODE_LF = 3'b110,
      MODE_INCR = 3'b111
   } tpb_mode_t;

   localparam logic [1:0] WSEL_8 = 2'h0;
   localparam logic [1:0] WSEL_10 = 2'h1;
   localparam logic [1:0] WSEL_16 = 2'h2;
   localparam logic [1:0] WSEL_20 = 2'h3;
   localparam logic [4:0] NBITS_8 = 5'h08;
   localparam logic [4:0] NBITS_10 = 5'h0A;
   localparam logic [4:0] NBITS_16 = 5'h10;
   localparam logic [4:0] NBITS_20 = 5'h14;

   // polynomial orders and feedback taps
   localparam logic [4:0] P7_ORDER = 5'h07;
   localparam logic [4:0] P7_TAP = 5'h06;
   localparam logic [4:0] P8_ORDER = 5'h08;
   localparam logic [4:0] P8_TAP = 5'h07;
   localparam logic [4:0] P10_ORDER = 5'h0A;
   localparam logic [4:0] P10_TAP = 5'h07;
   localparam logic [4:0] P23_ORDER = 5'h17;
   localparam logic [4:0] P23_TAP = 5'h12;
   localparam logic [22:0] LFSR_SEED = 23'h7FFFFF;

   // word alignment patterns
   localparam logic [39:0] ALIGN_P7 = 40'h0000003040;
   localparam logic [39:0] ALIGN_P7_20 = 40'h0000043040;
   localparam logic [39:0] ALIGN_P8 = 40'h000000FF5A;
   localparam logic [39:0] ALIGN_P10 = 40'h00000003FF;
   localparam logic [39:0] ALIGN_P23_8 = 40'h000000FFFF;
   localparam logic [39:0] ALIGN_P23_16 = 40'h00007FFFFF;
   localparam logic [39:0] ALIGN_P23_20 = 40'h00007FFFFF;

   // fixed clock-test words
   localparam logic [19:0] HF_WORD = 20'h55555;
   localparam logic [19:0] LF_WORD_10 = 20'h0001F;
   localparam logic [19:0] LF_WORD_20 = 20'h003FF;

   // =====================================================
   // checker states
   typedef enum logic [1:0] {
      CHK_IDLE = 2'b00,
      CHK_SEED = 2'b01,
      CHK_RUN = 2'b10,
      CHK_HOLD = 2'b11
   } tpb_chk_state_t;

endpackage : tpb_pkg

/* verilog/tpb_prbs_step.sv */
`timescale 1ns/1ns
`default_nettype none

// advances an LFSR by a run-time number of bits; in load mode the received
// bits are shifted in instead of the feedback, which seeds the checker
module tpb_prbs_step
   import tpb_pkg::*;
(
   // polynomial selection
   input wire logic [4:0] order,
   input wire logic [4:0] tap,
   input wire logic [4:0] nbits,
   // state and data
   input wire logic [22:0] state_in,
   input wire logic load,
   input wire logic [19:0] data,
   output logic [22:0] state_out,
   output logic [19:0] bits
);

   always_comb begin
      logic [22:0] s;
      logic b;
      s = state_in;
      b = 1'b0;
      bits = 20'h00000;
      for (int i = 0; i < TPB_LANE_W; i++) begin
         if (5'(i) < nbits) begin
            b = load ? data[i] : (s[order - 5'h01] ^ s[tap - 5'h01]);
            bits[i] = b;
            s = {s[21:0], b} & ~(23'h7FFFFF << order);
         end
      end
      state_out = s;
   end

endmodule : tpb_prbs_step

`default_nettype wire

/* verification/tpb_lpbk_model.sv */
`timescale 1ns/1ns
`default_nettype none

// =====================================================
// serial loopback stand-in: serializer word back to aligner output
module tpb_lpbk_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // from generator, error injection, lock request
   input wire logic [19:0] tx_word,
   input wire logic [19:0] flip,
   input wire logic lock,
   // towards checker
   output logic [19:0] rx_word,
   output logic rx_lock
);
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_word <= 20'h00000;
         rx_lock <= 1'b0;
      end else begin
         rx_lock <= lock;
         // out of lock the word toggles so no stale value can pass as data
         rx_word <= lock ? (tx_word ^ flip) : ~rx_word;
      end
   end
endmodule : tpb_lpbk_model

`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_top
   import tpb_pkg::*;
;
   typedef struct packed {
      logic [8:0] c;
      logic [39:0] al;
      logic [19:0] tx;
      logic t;
   } tpb_row_t;

   logic clk, rst, psel, penable, pwrite, pready, pslverr, codec_bypass;
   logic ser_lpbk_en, rx_sync_status, tx_digital_reset, rx_digital_reset;
   logic ser_lpbk_req, rx_done, rx_err, irq, lock, er_v;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic [19:0] tx_par_data, rx_aligned_data, flip;
   logic [39:0] align_pattern;
   logic [7:0] q[$];
   int bad_count, tests_run, n;
   int cyc = 0;

   localparam tpb_row_t ROWS[14] = '{
      '{9'h001, ALIGN_P7, 20'h0, 1'b0}, '{9'h011, ALIGN_P7, 20'h0, 1'b0},
      '{9'h019, ALIGN_P7_20, 20'h0, 1'b0}, '{9'h002, ALIGN_P8, 20'h0, 1'b0},
      '{9'h00B, ALIGN_P10, 20'h0, 1'b0}, '{9'h004, ALIGN_P23_8, 20'h0, 1'b0},
      '{9'h014, ALIGN_P23_16, 20'h0, 1'b0}, '{9'h01C, ALIGN_P23_20, 20'h0, 1'b0},
      '{9'h00A, 40'h0, 20'h0, 1'b1}, '{9'h005, 40'h0, 20'h00055, 1'b1},
      '{9'h01D, 40'h0, 20'h55555, 1'b1}, '{9'h01E, 40'h0, 20'h003FF, 1'b1},
      '{9'h007, 40'h0, 20'h0, 1'b1}, '{9'h027, 40'h0, 20'h00001, 1'b1}};

   always #25 clk = ~clk;

   tpb_prbs_self_test tpb_prbs_self_test_inst (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_par_data(tx_par_data),
      .codec_bypass(codec_bypass), .ser_lpbk_en(ser_lpbk_en),
      .rx_aligned_data(rx_aligned_data), .rx_sync_status(rx_sync_status),
      .align_pattern(align_pattern), .tx_digital_reset(tx_digital_reset),
      .rx_digital_reset(rx_digital_reset), .ser_lpbk_req(ser_lpbk_req),
      .rx_done(rx_done), .rx_err(rx_err), .irq(irq));

   tpb_lpbk_model tpb_lpbk_model_inst (.clk(clk), .rst(rst), .tx_word(tx_par_data),
      .flip(flip), .lock(lock), .rx_word(rx_aligned_data), .rx_lock(rx_sync_status));

   // =====================================================
   // checking and bus tasks
   task automatic conclude();
      $display("checks %0d wrong %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // waits for pready with no assumed latency; starting on a fresh edge
   // keeps back-to-back calls from assigning psel twice in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // pready ends this wait; if it never comes, only the bench timeout does
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd_v = prdata;
      er_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, {8'h00, e}, {8'h00, rd_v});
   endtask : rd

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         $display("timeout");
         bad_count++;
         conclude();
      end
   end

   // =====================================================
   // main sequence
   initial begin
      clk = 0;
      rst = 1;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 8'h00;
      pwdata = 32'h0;
      lock = 0;
      flip = 20'h0;
      tx_digital_reset = 0;
      rx_digital_reset = 0;
      ser_lpbk_req = 0;
      bad_count = 0;
      tests_run = 0;
      repeat (5) @(posedge clk);
      chk("tx word in reset", 40'h0, tx_par_data);
      rst <= 1'b0;
      rd(ADDR_CTRL, 32'h0, "ctrl reset");
      rd(ADDR_IRQ_MASK, 32'h0, "mask reset");
      rd(8'h10, 32'h0, "unmapped data");
      chk("unmapped slverr", 40'h1, er_v);
      $display("test reset finished");
      foreach (ROWS[i]) begin
         apb(1'b1, ADDR_CTRL, {23'h0, ROWS[i].c});
         repeat (2) @(posedge clk);
         chk("align", ROWS[i].al, align_pattern);
         chk("bypass", 40'h1, codec_bypass);
         chk("done gated", 40'h0, rx_done);
         if (ROWS[i].t) chk("word", ROWS[i].tx, tx_par_data);
      end
      $display("test table finished");
      apb(1'b1, ADDR_IRQ_MASK, 32'h3);
      // soft resets restart generator and checker from the seed
      apb(1'b1, ADDR_CTRL, 32'h0C1);
      apb(1'b1, ADDR_CTRL, 32'h1);
      lock <= 1'b1;
      @(posedge clk);
      repeat (254) begin
         @(posedge clk);
         q.push_back(tx_par_data[7:0]);
      end
      n = 0;
      for (int i = 0; i < 127; i++) if (q[i] !== q[i + 127]) n++;
      chk("period", 40'h0, n);
      chk("upper bits", 40'h0, tx_par_data[19:8]);
      chk("done", 40'h1, rx_done);
      chk("no error", 40'h0, rx_err);
      chk("irq done", 40'h1, irq);
      rd(ADDR_STATUS, 32'h5, "status done");
      rd(ADDR_IRQ_STAT, 32'h1, "irq stat");
      apb(1'b1, ADDR_IRQ_STAT, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq cleared", 40'h0, irq);
      $display("test prbs finished");
      flip <= 20'h00004;
      @(posedge clk);
      flip <= 20'h0;
      while (rx_err !== 1'b1) begin
         @(posedge clk);
      end
      repeat (20) @(posedge clk);
      chk("err sticky", 40'h1, rx_err);
      chk("done on err", 40'h1, rx_done);
      chk("irq err", 40'h1, irq);
      rd(ADDR_STATUS, 32'h3, "status err");
      rx_digital_reset <= 1'b1;
      repeat (5) @(posedge clk);
      chk("err cleared", 40'h0, rx_err);
      chk("done cleared", 40'h0, rx_done);
      rx_digital_reset <= 1'b0;
      tx_digital_reset <= 1'b1;
      repeat (5) @(posedge clk);
      chk("tx cleared", 40'h0, tx_par_data);
      tx_digital_reset <= 1'b0;
      repeat (5) @(posedge clk);
      // second word from the seed is the upper byte of the prbs7 alignment word
      chk("tx restarted", 40'h30, tx_par_data);
      $display("test error finished");
      apb(1'b1, ADDR_CTRL, 32'h101);
      ser_lpbk_req <= 1'b1;
      repeat (5) @(posedge clk);
      chk("loopback on", 40'h1, ser_lpbk_en);
      apb(1'b1, ADDR_CTRL, 32'h105);
      repeat (2) @(posedge clk);
      chk("loopback hf", 40'h0, ser_lpbk_en);
      $display("test loopback finished");
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      chk("lpbk in reset", 40'h0, ser_lpbk_en);
      rd(ADDR_CTRL, 32'h0, "ctrl mid reset");
      chk("bypass mid reset", 40'h0, codec_bypass);
      $display("test mid reset finished");
      conclude();
   end
endmodule : tb_top

`default_nettype wire
